// file: logic/supervisor_pkg.sv
// constants and types for the converter enable and fault supervisor
// Overview of operation
// RQ1 - enable high starts switching through soft-start
// RQ2 - enable low stops all switching
// RQ3 - enable low over 150 us clears latch
// RQ4 - valid enable toggle restarts with fresh soft-start
// RQ5 - power-good low only fault-free and in window
// RQ6 - input lockouts auto-recover, other protections latch
// RQ7 - latched trip stays off until reset/enable
// RQ8 - input below low fall level stops switching
// RQ9 - input reset level clears every stored protection
// RQ10 - input recovery soft-starts or waits per enable
// RQ11 - input overvoltage stops, recovery follows enable
// RQ12 - input overvoltage leaves latched state untouched
// RQ13 - feedback undervoltage stops switching, releases power-good
// RQ14 - undervoltage masked in soft-start, checked at end
// RQ15 - output undervoltage latches off until reset/toggle
// RQ16 - feedback overvoltage stops switching at once
// RQ17 - fail-safe 31 V overvoltage shuts down at once
// RQ18 - both overvoltage protections latch off
// RQ19 - overload handled by latching undervoltage trip
// RQ20 - over-temperature stops, releases power-good, latches
// RQ21 - temperature latch clears only after flag recovery
// RQ22 - 3 ms deglitch before first power-good
// RQ23 - bias not reached by timeout: safe shutdown; the default timeout outlasts the soft-start ramp, so it never trips
// RQ24 - synchronise inputs, count enable-low time
// RQ25 - power-good released outside normal operation
package supervisor_pkg;
   localparam int CLK_MHZ        = 100;    // pclk rate
   localparam int EN_LOW_US      = 150;    // least enable-low for a reset
   localparam int SS_STEP_US     = 128;    // one soft-start reference step
   localparam int SS_STEPS       = 7;      // steps in the soft-start ramp
   localparam int DEGLITCH_US    = 3000;   // settle time before power-good
   localparam int SS_TIMEOUT_US  = 1000;   // bias timeout; longer than the 896 us ramp, never reached
   localparam int EN_LOW_CYC     = EN_LOW_US * CLK_MHZ;
   localparam int SS_LEN_CYC     = SS_STEPS * SS_STEP_US * CLK_MHZ;
   localparam int DEGLITCH_CYC   = DEGLITCH_US * CLK_MHZ;
   localparam int SS_TIMEOUT_CYC = SS_TIMEOUT_US * CLK_MHZ;
   localparam int CNT_W          = 20;     // timer width, holds 3 ms

   // register byte offsets
   localparam logic [11:0] STATUS_OFS  = 12'h000;
   localparam logic [11:0] FLAGS_OFS   = 12'h004;
   localparam logic [11:0] CAUSE_OFS   = 12'h008;
   localparam logic [11:0] CONTROL_OFS = 12'h00C;
   localparam logic        HOLD_RST    = 1'b0;  // control reset value

   // synchronised flag positions
   localparam int F_EN = 0, F_RST = 1, F_ILOW = 2, F_IHIGH = 3;
   localparam int F_BIAS = 4, F_MLOW = 5, F_ALOW = 6, F_MHIGH = 7;
   localparam int F_AHIGH = 8, F_FS = 9, F_OTP = 10, F_OTS = 11;
   localparam int NFLAG = 12;

   // latch cause bit positions
   localparam int C_UVP = 0, C_OVP = 1, C_FS = 2, C_OT = 3, C_SST = 4;
   localparam int NCAUSE = 5;

   typedef enum logic [2:0] {
      ST_LOCKOUT, ST_DISABLED, ST_SOFT, ST_SETTLE, ST_NORMAL, ST_LATCHED
   } sup_state_t;
endpackage

// file: logic/converter_enable_fault_supervisor.sv
// enable, power-good and protection supervisor with apb status registers
`timescale 1ns/1ps
module converter_enable_fault_supervisor #(
   parameter int EN_LOW_CYC     = supervisor_pkg::EN_LOW_CYC,
   parameter int SS_LEN_CYC     = supervisor_pkg::SS_LEN_CYC,
   parameter int DEGLITCH_CYC   = supervisor_pkg::DEGLITCH_CYC,
   parameter int SS_TIMEOUT_CYC = supervisor_pkg::SS_TIMEOUT_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        enable_input,
   input  wire logic        input_reset_level,
   input  wire logic        input_low_lockout,
   input  wire logic        input_high_lockout,
   input  wire logic        main_bias_ok,
   input  wire logic        main_low_trip,
   input  wire logic        aux_low_trip,
   input  wire logic        main_high_trip,
   input  wire logic        aux_high_trip,
   input  wire logic        failsafe_high_level,
   input  wire logic        primary_overtemp_flag,
   input  wire logic        secondary_overtemp_flag,
   output logic             switch_enable,
   output logic             soft_start_active,
   output logic             power_good_n_o,
   output logic             power_good_n_oe
);
   localparam int CW = supervisor_pkg::CNT_W;
   localparam logic [CW-1:0] EN_LOW_LIM = CW'(EN_LOW_CYC);
   localparam logic [CW-1:0] SS_LAST    = CW'(SS_LEN_CYC - 1);
   localparam logic [CW-1:0] DG_LAST    = CW'(DEGLITCH_CYC - 1);
   localparam logic [CW-1:0] SS_TO      = CW'(SS_TIMEOUT_CYC);

   // raw flag bundle, first and second synchroniser stages
   logic [supervisor_pkg::NFLAG-1:0] raw_flags;
   logic [supervisor_pkg::NFLAG-1:0] meta_ff;    // read only by sync_ff
   logic [supervisor_pkg::NFLAG-1:0] sync_ff;    // usable flags
   logic                             en_d_ff;    // enable one cycle ago

   // control state
   supervisor_pkg::sup_state_t state_ff, nxt_state;
   logic [CW-1:0]    cnt_ff, nxt_cnt;          // soft-start / settle timer
   logic [CW-1:0]    en_low_ff;                // enable-low duration
   logic             latched_ff, nxt_latched;  // latched-off protection
   logic [supervisor_pkg::NCAUSE-1:0] cause_ff, nxt_cause;
   logic             hold_ff;                  // software switching inhibit

   // output flops
   logic             sw_en_ff;
   logic             ss_ff;
   logic             pg_oe_ff;
   logic [31:0]      prdata_ff;
   logic             pready_ff;
   logic             pslverr_ff;

   // decoded helpers
   logic             en_s, rst_s, ilow_s, ihigh_s, bias_s;
   logic             mlow_s, alow_s, mhigh_s, ahigh_s, fs_s, ot_s;
   logic             running, toggle_ok, ss_end;
   logic [supervisor_pkg::NCAUSE-1:0] trips;
   logic             nxt_running;

   assign raw_flags = {secondary_overtemp_flag, primary_overtemp_flag,
                       failsafe_high_level, aux_high_trip, main_high_trip,
                       aux_low_trip, main_low_trip, main_bias_ok,
                       input_high_lockout, input_low_lockout,
                       input_reset_level, enable_input};

   // two-flop synchroniser on every pin flag [RQ24]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= raw_flags;
         sync_ff <= meta_ff;
      end
   end

   assign en_s    = sync_ff[supervisor_pkg::F_EN];
   assign rst_s   = sync_ff[supervisor_pkg::F_RST];
   assign ilow_s  = sync_ff[supervisor_pkg::F_ILOW];
   assign ihigh_s = sync_ff[supervisor_pkg::F_IHIGH];
   assign bias_s  = sync_ff[supervisor_pkg::F_BIAS];
   assign mlow_s  = sync_ff[supervisor_pkg::F_MLOW];
   assign alow_s  = sync_ff[supervisor_pkg::F_ALOW];
   assign mhigh_s = sync_ff[supervisor_pkg::F_MHIGH];
   assign ahigh_s = sync_ff[supervisor_pkg::F_AHIGH];
   assign fs_s    = sync_ff[supervisor_pkg::F_FS];
   assign ot_s    = sync_ff[supervisor_pkg::F_OTP] |
                    sync_ff[supervisor_pkg::F_OTS];

   // enable-low timer, saturates so a long low never wraps [RQ24] [RQ3]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_d_ff   <= 1'b0;
         en_low_ff <= '0;
      end else begin
         en_d_ff <= en_s;
         if (en_s) begin
            en_low_ff <= en_low_ff;
         end else if (!en_d_ff && en_low_ff != EN_LOW_LIM) begin
            en_low_ff <= en_low_ff + CW'(1);
         end else if (en_d_ff) begin
            en_low_ff <= CW'(1);
         end
      end
   end

   // a rising enable after a long enough low counts as a latch reset [RQ3]
   assign toggle_ok = en_s && !en_d_ff && (en_low_ff >= EN_LOW_LIM);

   assign running = (state_ff == supervisor_pkg::ST_SOFT) ||
                    (state_ff == supervisor_pkg::ST_SETTLE) ||
                    (state_ff == supervisor_pkg::ST_NORMAL);
   assign ss_end  = (state_ff == supervisor_pkg::ST_SOFT) &&
                    (cnt_ff == SS_LAST);

   // protection trips; undervoltage masked while soft-start ramps
   always_comb begin
      trips = '0;
      // feedback undervoltage, also catches overload droop [RQ13] [RQ19]
      if (((state_ff == supervisor_pkg::ST_SETTLE ||
            state_ff == supervisor_pkg::ST_NORMAL) && (mlow_s || alow_s)) ||
          (ss_end && (mlow_s || alow_s))) begin
         trips[supervisor_pkg::C_UVP] = 1'b1;   // [RQ14] [RQ15]
      end
      // feedback overvoltage [RQ16]
      trips[supervisor_pkg::C_OVP] = running && (mhigh_s || ahigh_s);
      // fail-safe level ignores the feedback senses [RQ17]
      trips[supervisor_pkg::C_FS]  = running && fs_s;
      // either stage over temperature [RQ20]
      trips[supervisor_pkg::C_OT]  = running && ot_s;
      // bias not reached in time: safe shutdown [RQ23]
      trips[supervisor_pkg::C_SST] =
         (state_ff == supervisor_pkg::ST_SOFT) && !bias_s &&
         (cnt_ff >= SS_TO);
   end

   // mode sequencing and latch bookkeeping
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_latched = latched_ff;
      nxt_cause   = cause_ff;
      if (rst_s) begin
         // reset level wipes every stored protection [RQ9]
         nxt_latched = 1'b0;
         nxt_cause   = '0;
         nxt_state   = supervisor_pkg::ST_LOCKOUT;
         nxt_cnt     = '0;
      end else begin
         // latch release needs the temperature flag to have recovered
         if (toggle_ok && latched_ff && !ot_s) begin   // [RQ4] [RQ21]
            nxt_latched = 1'b0;
            nxt_cause   = '0;
         end
         // any non-input protection latches; a new trip wins over a clear
         if (|trips) begin                             // [RQ6] [RQ18]
            nxt_latched = 1'b1;
            nxt_cause   = nxt_cause | trips;
         end
         if (ilow_s || ihigh_s) begin
            // auto-recovery lockout, latch untouched [RQ8] [RQ11] [RQ12]
            nxt_state = supervisor_pkg::ST_LOCKOUT;
            nxt_cnt   = '0;
         end else if (nxt_latched) begin
            // stays off until reset level or valid toggle [RQ7]
            nxt_state = supervisor_pkg::ST_LATCHED;
            nxt_cnt   = '0;
         end else if (!en_s || hold_ff) begin
            // enable low turns the converter off [RQ2] [RQ10]
            nxt_state = supervisor_pkg::ST_DISABLED;
            nxt_cnt   = '0;
         end else begin
            case (state_ff)
               supervisor_pkg::ST_SOFT: begin
                  nxt_cnt = cnt_ff + CW'(1);
                  if (ss_end) begin
                     nxt_state = supervisor_pkg::ST_SETTLE;
                     nxt_cnt   = '0;
                  end
               end
               supervisor_pkg::ST_SETTLE: begin
                  // deglitch only before the first power-good [RQ22]
                  nxt_cnt = cnt_ff + CW'(1);
                  if (cnt_ff == DG_LAST) begin
                     nxt_state = supervisor_pkg::ST_NORMAL;
                     nxt_cnt   = '0;
                  end
               end
               supervisor_pkg::ST_NORMAL: begin
                  nxt_state = supervisor_pkg::ST_NORMAL;
               end
               default: begin
                  // enable high from any off state starts soft-start [RQ1]
                  nxt_state = supervisor_pkg::ST_SOFT;     // [RQ10] [RQ11]
                  nxt_cnt   = '0;
               end
            endcase
         end
      end
   end

   assign nxt_running = (nxt_state == supervisor_pkg::ST_SOFT) ||
                        (nxt_state == supervisor_pkg::ST_SETTLE) ||
                        (nxt_state == supervisor_pkg::ST_NORMAL);

   // state, timer and latch registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff   <= supervisor_pkg::ST_LOCKOUT;
         cnt_ff     <= '0;
         latched_ff <= 1'b0;
         cause_ff   <= '0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         latched_ff <= nxt_latched;
         cause_ff   <= nxt_cause;
      end
   end

   // pin outputs follow the next state so they align with state_ff
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_en_ff <= 1'b0;
         ss_ff    <= 1'b0;
         pg_oe_ff <= 1'b0;
      end else begin
         sw_en_ff <= nxt_running;                          // [RQ1] [RQ2]
         ss_ff    <= (nxt_state == supervisor_pkg::ST_SOFT);
         // pull low only in normal mode, in window, no fault [RQ5] [RQ25]
         pg_oe_ff <= (nxt_state == supervisor_pkg::ST_NORMAL) &&
                     !mlow_s && !alow_s && !mhigh_s && !ahigh_s &&
                     !fs_s && !ot_s;
      end
   end

   // apb slave: answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
         hold_ff    <= supervisor_pkg::HOLD_RST;
      end else begin
         pready_ff  <= psel && penable && !pready_ff;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
         if (psel && penable && !pready_ff) begin
            case (paddr)
               supervisor_pkg::STATUS_OFS:
                  prdata_ff <= {26'h0000000, en_s, latched_ff,
                                1'b0, state_ff};
               supervisor_pkg::FLAGS_OFS:
                  prdata_ff <= {20'h00000, sync_ff};
               supervisor_pkg::CAUSE_OFS:
                  prdata_ff <= {27'h0000000, cause_ff};
               supervisor_pkg::CONTROL_OFS: begin
                  prdata_ff <= {31'h00000000, hold_ff};
                  if (pwrite) begin
                     hold_ff <= pwdata[0];
                  end
               end
               default: pslverr_ff <= 1'b1;   // unmapped address
            endcase
         end
      end
   end

   assign prdata            = prdata_ff;
   assign pready            = pready_ff;
   assign pslverr           = pslverr_ff;
   assign switch_enable     = sw_en_ff;
   assign soft_start_active = ss_ff;
   assign power_good_n_o    = 1'b0 & pg_oe_ff;   // open drain: drives low
   assign power_good_n_oe   = pg_oe_ff;

   // checks
   sequence s_long_low;
      en_low_ff >= EN_LOW_LIM && !en_s;
   endsequence
   sequence s_toggle;
      s_long_low ##1 en_s;
   endsequence

   a_enable_low_stop: assert property (@(posedge pclk) disable iff (!presetn)
      !en_s |=> !switch_enable)     // [RQ2]
      else $error("switching continued with enable low");
   a_toggle_restart: assert property (@(posedge pclk) disable iff (!presetn)
      s_toggle ##0 (latched_ff && !ot_s && !rst_s && !ilow_s && !ihigh_s
       && !hold_ff && trips == '0) |=> state_ff == supervisor_pkg::ST_SOFT)
      else $error("valid enable toggle did not restart");   // [RQ4]
   a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
      latched_ff && !rst_s && !toggle_ok |=> latched_ff && !switch_enable)
      else $error("latched-off state left without reset"); // [RQ7]
   a_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
      rst_s |=> !latched_ff && cause_ff == '0)
      else $error("reset level did not clear protections"); // [RQ9]
   a_input_low_stop: assert property (@(posedge pclk) disable iff (!presetn)
      ilow_s |=> !switch_enable)     // [RQ8]
      else $error("switching during input undervoltage");
   a_input_high_lockout_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      latched_ff && ihigh_s && !rst_s && !toggle_ok |=> latched_ff)
      else $error("input overvoltage changed latch");   // [RQ12]
   a_ovp_latch: assert property (@(posedge pclk) disable iff (!presetn)
      running && (mhigh_s || ahigh_s) && !rst_s
      |=> !switch_enable && cause_ff[supervisor_pkg::C_OVP])
      else $error("feedback overvoltage not latched");  // [RQ16]
   a_failsafe_off: assert property (@(posedge pclk) disable iff (!presetn)
      running && fs_s && !rst_s |=> !switch_enable && latched_ff)
      else $error("fail-safe overvoltage ignored");     // [RQ17]
   a_overtemp_off: assert property (@(posedge pclk) disable iff (!presetn)
      running && ot_s && !rst_s |=> !switch_enable && !power_good_n_oe)
      else $error("over-temperature did not stop");     // [RQ20]
   a_pg_normal: assert property (@(posedge pclk) disable iff (!presetn)
      power_good_n_oe |-> state_ff == supervisor_pkg::ST_NORMAL)
      else $error("power-good pulled outside normal");  // [RQ25]
   a_uvp_at_end: assert property (@(posedge pclk) disable iff (!presetn)
      ss_end && (mlow_s || alow_s) && !rst_s
      |=> cause_ff[supervisor_pkg::C_UVP] ##0 !switch_enable)
      else $error("undervoltage at soft-start end missed"); // [RQ14]
endmodule // converter_enable_fault_supervisor

// file: bench/pg_controller.sv
// system controller model: drives enable, reads the open-drain power-good
`timescale 1ns/1ps
module pg_controller (
   input  wire logic pclk,             // shared clock
   output logic      enable_input,     // enable level toward the block
   input  wire logic power_good_n_o,   // pin drive value
   input  wire logic power_good_n_oe,  // pin pulled while high
   output wire logic power_good_n      // resolved pin level
);
   // external pull-up lifts the line whenever the block lets go of it
   assign power_good_n = (power_good_n_oe === 1'b1) ? power_good_n_o
                                                    : 1'b1;

   // enable rests low at start, as the weak pull-down on the pin would
   initial begin
      enable_input = 1'b0;
   end

   // plain level change, launched just after an edge
   task drive_enable(input logic v);
      @(posedge pclk);
      enable_input <= v;
   endtask

   // low pulse then back high; a long pulse is the latch reset
   task toggle(input int low_cyc);
      @(posedge pclk);
      enable_input <= 1'b0;
      repeat (low_cyc) @(posedge pclk);
      enable_input <= 1'b1;
   endtask
endmodule // pg_controller

// file: bench/converter_enable_fault_supervisor_bench.sv
// self-checking bench for the enable and fault supervisor
`timescale 1ns/1ps
module converter_enable_fault_supervisor_bench;
   typedef struct {
      int         bit_i;  // flag position to raise
      logic       lat;    // protection latches
      logic [4:0] cause;  // expected cause bits
   } row_t;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, rerr, enable_input, power_good_n;
   logic        switch_enable, soft_start_active, pg_o, pg_oe;
   logic [11:0] fl;                    // comparator flags, bit order of pkg
   int          fails, checks_done, cyc;
   // fault per row: lockouts recover, the rest latch with a cause
   row_t rows [9] = '{
      '{supervisor_pkg::F_ILOW,  1'b0, 5'h00},
      '{supervisor_pkg::F_IHIGH, 1'b0, 5'h00},
      '{supervisor_pkg::F_MLOW,  1'b1, 5'h01},
      '{supervisor_pkg::F_ALOW,  1'b1, 5'h01},
      '{supervisor_pkg::F_MHIGH, 1'b1, 5'h02},
      '{supervisor_pkg::F_AHIGH, 1'b1, 5'h02},
      '{supervisor_pkg::F_FS,    1'b1, 5'h04},
      '{supervisor_pkg::F_OTP,   1'b1, 5'h08},
      '{supervisor_pkg::F_OTS,   1'b1, 5'h08}};

   // short counts keep the run brief; timeout sits below the ramp length
   converter_enable_fault_supervisor #(.EN_LOW_CYC(20), .SS_LEN_CYC(40),
      .DEGLITCH_CYC(30), .SS_TIMEOUT_CYC(30)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enable_input(enable_input),
      .input_reset_level(fl[1]), .input_low_lockout(fl[2]),
      .input_high_lockout(fl[3]), .main_bias_ok(fl[4]),
      .main_low_trip(fl[5]), .aux_low_trip(fl[6]),
      .main_high_trip(fl[7]), .aux_high_trip(fl[8]),
      .failsafe_high_level(fl[9]), .primary_overtemp_flag(fl[10]),
      .secondary_overtemp_flag(fl[11]), .switch_enable(switch_enable),
      .soft_start_active(soft_start_active), .power_good_n_o(pg_o),
      .power_good_n_oe(pg_oe));
   pg_controller i_ctl (.pclk(pclk), .enable_input(enable_input),
      .power_good_n_o(pg_o), .power_good_n_oe(pg_oe),
      .power_good_n(power_good_n));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) begin
         fails++;
         give_verdict();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // 0 switching on, 1 power good, 2 switching off
   function logic probe(input int sel);
      case (sel)
         0: probe = switch_enable;
         1: probe = ~power_good_n;
         default: probe = ~switch_enable;
      endcase
   endfunction

   // bounded wait; a hang counts as a mismatch and ends the run
   task wait_for(input int sel);
      cyc = 0;
      while (probe(sel) !== 1'b1 && cyc < 300) begin
         @(posedge pclk);
         cyc++;
      end
      if (cyc >= 300) begin
         fails++;
         $display("unexpected wait expired on probe %0d", sel);
         give_verdict();
      end
   endtask

   // latched check: status state and cause register
   task chk_latch(input logic [2:0] st, input logic [4:0] cz);
      apb(1'b0, supervisor_pkg::STATUS_OFS, 32'h0);
      chk("state", rdat[2:0], st);
      apb(1'b0, supervisor_pkg::CAUSE_OFS, 32'h0);
      chk("cause", rdat[4:0], cz);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fl = 12'h010;  // bias present, no faults
      fails = 0;
      checks_done = 0;
      repeat (10) @(posedge pclk);
      chk("switch in reset", switch_enable, 1'b0);
      chk("pg in reset", power_good_n, 1'b1);
      presetn <= 1'b1;
      // registers: rw control, read-only status, unmapped address
      apb(1'b1, supervisor_pkg::CONTROL_OFS, 32'h1);
      apb(1'b0, supervisor_pkg::CONTROL_OFS, 32'h0);
      chk("control", rdat[0], 1'b1);
      apb(1'b1, supervisor_pkg::CONTROL_OFS, 32'h0);
      apb(1'b1, supervisor_pkg::STATUS_OFS, 32'hFFFFFFFF);
      chk("status err", rerr, 1'b0);
      apb(1'b0, supervisor_pkg::STATUS_OFS, 32'h0);
      chk("disabled", rdat[2:0], 3'h1);
      apb(1'b0, supervisor_pkg::FLAGS_OFS, 32'h0);
      chk("flags", rdat[11:0], 12'h010);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped err", rerr, 1'b1);
      $display("register test done");
      // bring-up: soft-start, then power good only after the deglitch
      i_ctl.drive_enable(1'b1);
      wait_for(0);
      chk("soft start", soft_start_active, 1'b1);
      chk("pg in soft", power_good_n, 1'b1);
      wait_for(1);
      chk("pg delay min", cyc >= 70, 1'b1);
      chk("pg delay max", cyc <= 80, 1'b1);
      $display("bring-up test done");
      for (int i = 0; i < 9; i++) begin
         fl[rows[i].bit_i] <= 1'b1;
         repeat (6) @(posedge pclk);
         chk("switch off", switch_enable, 1'b0);
         chk("pg released", power_good_n, 1'b1);
         chk_latch(rows[i].lat ? 3'h5 : 3'h0, rows[i].cause);
         fl[rows[i].bit_i] <= 1'b0;
         repeat (6) @(posedge pclk);
         if (rows[i].lat) begin
            chk("stays off", switch_enable, 1'b0);
            i_ctl.toggle(25);
         end
         wait_for(0);
         chk("restart soft", soft_start_active, 1'b1);
         wait_for(1);
         $display("fault row %0d done", i);
      end
      // temperature latch held while flag high; overvoltage keeps latch
      fl[10] <= 1'b1;
      repeat (6) @(posedge pclk);
      i_ctl.toggle(25);
      repeat (8) @(posedge pclk);
      chk_latch(3'h5, 5'h08);
      fl[3] <= 1'b1;
      repeat (6) @(posedge pclk);
      fl[3] <= 1'b0;
      fl[10] <= 1'b0;
      repeat (6) @(posedge pclk);
      chk_latch(3'h5, 5'h08);
      i_ctl.toggle(10);
      repeat (8) @(posedge pclk);
      chk_latch(3'h5, 5'h08);
      // supply below reset level clears the latch
      fl[2:1] <= 2'b11;
      repeat (6) @(posedge pclk);
      chk_latch(3'h0, 5'h00);
      fl[2:1] <= 2'b00;
      wait_for(0);
      chk("soft after supply", soft_start_active, 1'b1);
      wait_for(1);
      $display("latch clear test done");
      // enable low stops switching
      i_ctl.drive_enable(1'b0);
      wait_for(2);
      chk("cycles to stop", cyc <= 6, 1'b1);
      chk("pg off disabled", power_good_n, 1'b1);
      // undervoltage masked in soft-start, trips at its end
      fl[5] <= 1'b1;
      i_ctl.drive_enable(1'b1);
      wait_for(0);
      repeat (20) @(posedge pclk);
      chk("masked", switch_enable, 1'b1);
      wait_for(2);
      chk_latch(3'h5, 5'h01);
      fl[5] <= 1'b0;
      // missing bias ends in safe shutdown by the timeout
      fl[4] <= 1'b0;
      i_ctl.toggle(25);
      wait_for(0);
      wait_for(2);
      chk("timeout before end", cyc < 40, 1'b1);
      chk_latch(3'h5, 5'h10);
      $display("soft-start fault test done");
      give_verdict();
   end
endmodule // converter_enable_fault_supervisor_bench
